// file: rtl/cpl_top.sv
// Logic fabric top: Wishbone configuration slave, pin synchronisers, switch matrix,
// four logic blocks and I/O cells. Assumes one 100 MHz clock; all pins asynchronous.
// Functional notes
// [RULE_01] Four identical logic blocks share a switch matrix fed by 32 I/O pins and 4 dedicated inputs.
// [RULE_02] Two clock pins exist and each may also feed the matrix as a plain data input.
// [RULE_03] Each block has 64 product terms, an allocator, 8+8 macrocells, 8 I/O cells and 22 routed inputs.
// [RULE_04] Each block also has two output-enable terms, one reset term and one preset term.
// [RULE_05] All storage of a block is cleared or set together by its reset and preset terms.
// [RULE_06] The matrix takes 16 macrocell and 8 pin feedbacks per block and routes them back to the blocks.
// [RULE_07] The allocator hands the 64 terms to the 16 macrocells, never more than 16 to one cell.
// [RULE_08] Macrocell k may draw only clusters k-1 to k+2, clipped to 0..15.
// [RULE_09] Macrocells are registered, latched or combinatorial with selectable polarity and always feed back.
// [RULE_10] Each macrocell register can act as a D or a T flip-flop.
// [RULE_11] Each register or latch picks one of the two clock pins as its clock or gate.
// [RULE_12] Registers load on the rising edge of their chosen clock.
// [RULE_13] Latches are transparent while their gate is low and hold while it is high.
// [RULE_14] Buried macrocells drive feedback only and may instead serve as input register or latch.
// [RULE_15] Each I/O buffer is always on, always off, or driven by one of the two output-enable terms.
// [RULE_16] A term is the AND of chosen true or inverted inputs; a cell ORs its terms then applies polarity.
// [RULE_17] In T mode the register inverts on the edge when its function is true and holds otherwise.
`timescale 1ns/1ps
module cpl_top
    import cpl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_IO-1:0] io_i,
    output logic [NUM_IO-1:0] io_o,
    output logic [NUM_IO-1:0] io_oe_o,
    input wire logic [NUM_DIN-1:0] din_i,
    input wire logic [NUM_CKP-1:0] ckp_i
);
    localparam logic [SEL_W-1:0] SRC_CK0 = 7'h24;
    localparam logic [SEL_W-1:0] SRC_FB0 = 7'h26;

    logic [NUM_PIN-1:0] s1_r;
    logic [NUM_PIN-1:0] s2_r;
    logic [NUM_PIN-1:0] s3_r;
    logic [NUM_PIN-1:0] pin_r;
    logic [NUM_CKP-1:0] ck_prev_r;
    logic [NUM_CKP-1:0] ck_lvl;
    logic [NUM_CKP-1:0] ck_rise;
    logic [NUM_SRC-1:0] src;
    logic [SEL_W-1:0] route_r [NUM_BLK][BLK_IN];
    logic [BLK_IN-1:0] bin_r [NUM_BLK];
    logic [NUM_MC-1:0] bmc [NUM_BLK];
    logic [IO_PER_BLK-1:0] boe [NUM_BLK];
    logic [31:0] brd [NUM_BLK];
    logic [NUM_IO-1:0] io_o_r;
    logic [NUM_IO-1:0] io_oe_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_nxt;
    logic req;
    logic adr_ok;
    logic route_hit;
    logic cfg_we;
    logic [1:0] blk_sel;
    logic [9:0] loc;
    logic [4:0] route_idx;

    // Level accepted only once the second and third stage agree
    function automatic logic [NUM_PIN-1:0] agree(input logic [NUM_PIN-1:0] a, input logic [NUM_PIN-1:0] b,
                                                 input logic [NUM_PIN-1:0] held);
        return (a & b) | (held & (a ^ b));
    endfunction

    // Unused selector codes read as zero
    function automatic logic pick(input logic [NUM_SRC-1:0] v, input logic [SEL_W-1:0] s);
        return (int'(s) < NUM_SRC) ? v[s] : 1'b0;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= {ckp_i, din_i, io_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= agree(s2_r, s3_r, pin_r);
        end
    end

    assign ck_lvl = pin_r[PIN_CK_LSB +: NUM_CKP];

    // Edges seen on the filtered level so pin glitches never clock a macrocell
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ck_prev_r <= '0;
        end else begin
            ck_prev_r <= ck_lvl;
        end
    end

    assign ck_rise = ck_lvl & ~ck_prev_r; // [RULE_12]

    // Source order: I/O pins, dedicated inputs, clock pins, then macrocell feedback by block
    always_comb begin
        src = '0;
        src[NUM_PIN-1:0] = pin_r; // [RULE_01] [RULE_02]
        for (int b = 0; b < NUM_BLK; b++) begin
            src[NUM_PIN + b*NUM_MC +: NUM_MC] = bmc[b]; // [RULE_06]
        end
    end

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign adr_ok = wb_adr_i[15:14] == 2'h0;
    assign blk_sel = wb_adr_i[13:12];
    assign loc = wb_adr_i[11:2];
    assign route_hit = loc >= ROUTE_BASE && loc < ROUTE_END;
    assign route_idx = 5'(loc - ROUTE_BASE);
    // Partial-word writes are acked but dropped; every field sits in one word
    assign cfg_we = req & wb_we_i & adr_ok & (wb_sel_i == SEL_ALL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int b = 0; b < NUM_BLK; b++) begin
                for (int i = 0; i < BLK_IN; i++) begin
                    route_r[b][i] <= ROUTE_RST;
                end
            end
        end else if (cfg_we && route_hit) begin
            route_r[blk_sel][route_idx] <= wb_dat_i[SEL_W-1:0];
        end
    end

    // Registered matrix breaks the loop through combinatorial feedback
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int b = 0; b < NUM_BLK; b++) begin
                bin_r[b] <= '0;
            end
        end else begin
            for (int b = 0; b < NUM_BLK; b++) begin
                for (int i = 0; i < BLK_IN; i++) begin
                    bin_r[b][i] <= pick(src, route_r[b][i]); // [RULE_06]
                end
            end
        end
    end

    for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
        cpl_blk u_blk ( // [RULE_01]
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_i(bin_r[b]),
            .io_i(pin_r[b*IO_PER_BLK +: IO_PER_BLK]),
            .ck_rise_i(ck_rise),
            .ck_lvl_i(ck_lvl),
            .cfg_we_i(cfg_we && !route_hit && blk_sel == 2'(b)),
            .cfg_idx_i(loc),
            .cfg_dat_i(wb_dat_i),
            .cfg_dat_o(brd[b]),
            .mc_o(bmc[b]),
            .oe_o(boe[b])
        );
    end

    always_comb begin
        rd_nxt = '0;
        if (adr_ok) begin
            if (route_hit) begin
                rd_nxt[SEL_W-1:0] = route_r[blk_sel][route_idx];
            end else begin
                rd_nxt = brd[blk_sel];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (req && !wb_we_i) begin
            dat_r <= rd_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Even macrocells own the pins; buried ones never reach a pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_o_r <= '0;
            io_oe_r <= '0;
        end else begin
            for (int b = 0; b < NUM_BLK; b++) begin
                for (int j = 0; j < IO_PER_BLK; j++) begin
                    io_o_r[b*IO_PER_BLK + j] <= bmc[b][2*j]; // [RULE_14]
                    io_oe_r[b*IO_PER_BLK + j] <= boe[b][j]; // [RULE_15]
                end
            end
        end
    end

    assign io_o = io_o_r;
    assign io_oe_o = io_oe_r;

    wb_ack_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i) req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single cycle after request");
    pin_filter_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> ((pin_r ^ $past(pin_r)) & ($past(s2_r) ^ $past(s3_r))) == '0)
        else $error("Pin level moved while stages disagreed");

    for (genvar b = 0; b < NUM_BLK; b++) begin : g_chk
        route_fb_a: assert property ( // [RULE_06]
            @(posedge clk_i) disable iff (rst_i)
            route_r[b][0] == SRC_FB0 |=> bin_r[b][0] == $past(bmc[0][0]))
            else $error("Feedback not routed to block input");
        ckp_data_a: assert property ( // [RULE_02]
            @(posedge clk_i) disable iff (rst_i)
            route_r[b][1] == SRC_CK0 |=> bin_r[b][1] == $past(ck_lvl[0]))
            else $error("Clock pin not usable as data");
        oe_follow_a: assert property ( // [RULE_15]
            @(posedge clk_i) disable iff (rst_i)
            1'b1 |=> io_oe_o[b*IO_PER_BLK +: IO_PER_BLK] == $past(boe[b]))
            else $error("Pin enable does not follow block");
    end
endmodule

// file: pkg/cpl_pkg.sv
// Shared constants and types of the programmable logic fabric.
// Assumes a single 100 MHz clock and a classic Wishbone slave for configuration.
package cpl_pkg;
    localparam int NUM_BLK = 4;
    localparam int NUM_IO = 32;
    localparam int NUM_DIN = 4;
    localparam int NUM_CKP = 2;
    localparam int BLK_IN = 22;
    localparam int NUM_PT = 64;
    localparam int NUM_SPT = 4;
    localparam int NUM_TERM = NUM_PT + NUM_SPT;
    localparam int NUM_MC = 16;
    localparam int NUM_CLU = 16;
    localparam int CLU_PT = 4;
    localparam int IO_PER_BLK = 8;
    localparam int NUM_PIN = NUM_IO + NUM_DIN + NUM_CKP;
    localparam int NUM_SRC = NUM_PIN + NUM_BLK * NUM_MC;
    localparam int SEL_W = 7;
    localparam int PIN_DIN_LSB = NUM_IO;
    localparam int PIN_CK_LSB = NUM_IO + NUM_DIN;
    localparam int PT_OE0 = 64;
    localparam int PT_OE1 = 65;
    localparam int PT_ARST = 66;
    localparam int PT_APRE = 67;
    // Word index inside one block; byte address = (block * 1024 + index) * 4
    localparam logic [9:0] TERM_END = 10'h088;
    localparam logic [9:0] MC_BASE = 10'h100;
    localparam logic [9:0] CLU_BASE = 10'h110;
    localparam logic [9:0] ROUTE_BASE = 10'h120;
    localparam logic [9:0] ROUTE_END = 10'h136;
    localparam logic [9:0] STAT_OFF = 10'h140;
    // Macrocell configuration word fields
    localparam int MC_CFG_W = 7;
    localparam int MC_MODE_LSB = 0;
    localparam int MC_POL = 2;
    localparam int MC_TFF = 3;
    localparam int MC_CKS = 4;
    localparam int MC_OE_LSB = 5;
    // Cluster steering word fields
    localparam int CLU_CFG_W = 3;
    localparam int CLU_EN = 0;
    localparam int CLU_OFF_LSB = 1;
    // Reset values; both literals set means the term is an erased zero
    localparam logic [BLK_IN-1:0] PT_MASK_RST = 22'h3FFFFF;
    localparam logic [MC_CFG_W-1:0] MC_CFG_RST = 7'h00;
    localparam logic [CLU_CFG_W-1:0] CLU_CFG_RST = 3'h0;
    localparam logic [SEL_W-1:0] ROUTE_RST = 7'h7F;
    localparam logic [3:0] SEL_ALL = 4'hF;

    typedef enum logic [1:0] {MD_COMB, MD_REG, MD_LATCH, MD_INPUT} cpl_mode_t;
    typedef enum logic [1:0] {OE_OFF, OE_ON, OE_PT0, OE_PT1} cpl_oe_t;
endpackage

// file: rtl/cpl_blk.sv
// One logic block: product terms, cluster allocator, 16 macrocells, output enables.
// Assumes routed inputs and filtered clock-pin levels and edges from the top.
`timescale 1ns/1ps
module cpl_blk
    import cpl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [BLK_IN-1:0] in_i,
    input wire logic [IO_PER_BLK-1:0] io_i,
    input wire logic [NUM_CKP-1:0] ck_rise_i,
    input wire logic [NUM_CKP-1:0] ck_lvl_i,
    input wire logic cfg_we_i,
    input wire logic [9:0] cfg_idx_i,
    input wire logic [31:0] cfg_dat_i,
    output logic [31:0] cfg_dat_o,
    output logic [NUM_MC-1:0] mc_o,
    output logic [IO_PER_BLK-1:0] oe_o
);
    logic [BLK_IN-1:0] tmask_r [NUM_TERM];
    logic [BLK_IN-1:0] cmask_r [NUM_TERM];
    logic [MC_CFG_W-1:0] mcfg_r [NUM_MC];
    logic [CLU_CFG_W-1:0] clu_r [NUM_CLU];
    logic [NUM_MC-1:0] st_r;
    logic [NUM_TERM-1:0] pt;
    logic [NUM_MC-1:0] sum;
    logic [NUM_MC-1:0] fn;
    logic arst;
    logic apre;

    function automatic logic pterm(input logic [BLK_IN-1:0] tm, input logic [BLK_IN-1:0] cm,
                                   input logic [BLK_IN-1:0] x);
        return (&(~tm | x)) & (&(~cm | ~x));
    endfunction

    // Output macrocells have no input-register path, so that code means combinatorial
    function automatic cpl_mode_t mode_of(input logic [MC_CFG_W-1:0] cfg, input int k);
        cpl_mode_t m;
        m = cpl_mode_t'(cfg[MC_MODE_LSB +: 2]);
        return (m == MD_INPUT && k % 2 == 0) ? MD_COMB : m;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                tmask_r[t] <= PT_MASK_RST;
                cmask_r[t] <= PT_MASK_RST;
            end
            for (int k = 0; k < NUM_MC; k++) begin
                mcfg_r[k] <= MC_CFG_RST;
                clu_r[k] <= CLU_CFG_RST;
            end
        end else if (cfg_we_i) begin
            if (cfg_idx_i < TERM_END) begin
                if (cfg_idx_i[0]) begin
                    cmask_r[cfg_idx_i[7:1]] <= cfg_dat_i[BLK_IN-1:0];
                end else begin
                    tmask_r[cfg_idx_i[7:1]] <= cfg_dat_i[BLK_IN-1:0];
                end
            end else if (cfg_idx_i[9:4] == MC_BASE[9:4]) begin
                mcfg_r[cfg_idx_i[3:0]] <= cfg_dat_i[MC_CFG_W-1:0];
            end else if (cfg_idx_i[9:4] == CLU_BASE[9:4]) begin
                clu_r[cfg_idx_i[3:0]] <= cfg_dat_i[CLU_CFG_W-1:0];
            end
        end
    end

    always_comb begin
        for (int t = 0; t < NUM_TERM; t++) begin
            pt[t] = pterm(tmask_r[t], cmask_r[t], in_i); // [RULE_16] [RULE_03]
        end
    end

    assign arst = pt[PT_ARST]; // [RULE_04]
    assign apre = pt[PT_APRE]; // [RULE_04]

    // Cluster c may feed macrocells c-2..c+1 only, one at a time, so no cell gets over 16 terms
    always_comb begin
        sum = '0;
        for (int c = 0; c < NUM_CLU; c++) begin
            for (int k = 0; k < NUM_MC; k++) begin
                if (clu_r[c][CLU_EN] && k == c - 2 + int'(clu_r[c][CLU_OFF_LSB +: 2])) begin // [RULE_07] [RULE_08]
                    sum[k] = sum[k] | (|pt[c*CLU_PT +: CLU_PT]);
                end
            end
        end
        for (int k = 0; k < NUM_MC; k++) begin
            fn[k] = sum[k] ^ mcfg_r[k][MC_POL]; // [RULE_16] [RULE_09]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            for (int k = 0; k < NUM_MC; k++) begin
                if (arst) begin
                    st_r[k] <= 1'b0; // [RULE_05]
                end else if (apre) begin
                    st_r[k] <= 1'b1; // [RULE_05]
                end else begin
                    unique case (mode_of(mcfg_r[k], k))
                        MD_COMB: st_r[k] <= st_r[k];
                        MD_REG: begin
                            if (ck_rise_i[mcfg_r[k][MC_CKS]]) begin // [RULE_11] [RULE_12]
                                st_r[k] <= mcfg_r[k][MC_TFF] ? st_r[k] ^ fn[k] : fn[k]; // [RULE_10] [RULE_17]
                            end
                        end
                        MD_LATCH: begin
                            if (!ck_lvl_i[mcfg_r[k][MC_CKS]]) begin // [RULE_13]
                                st_r[k] <= fn[k];
                            end
                        end
                        MD_INPUT: begin
                            // Tff bit picks input latch instead of input register
                            if (mcfg_r[k][MC_TFF] ? !ck_lvl_i[mcfg_r[k][MC_CKS]]
                                                  : ck_rise_i[mcfg_r[k][MC_CKS]]) begin // [RULE_14]
                                st_r[k] <= io_i[k/2];
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_comb begin
        for (int k = 0; k < NUM_MC; k++) begin
            unique case (mode_of(mcfg_r[k], k))
                MD_COMB: mc_o[k] = fn[k]; // [RULE_09]
                MD_REG: mc_o[k] = st_r[k];
                MD_LATCH: mc_o[k] = ck_lvl_i[mcfg_r[k][MC_CKS]] ? st_r[k] : fn[k]; // [RULE_13]
                MD_INPUT: mc_o[k] = (mcfg_r[k][MC_TFF] && !ck_lvl_i[mcfg_r[k][MC_CKS]]) ? io_i[k/2] : st_r[k];
            endcase
            if (mode_of(mcfg_r[k], k) != MD_COMB && (arst || apre)) begin
                mc_o[k] = !arst; // [RULE_05]
            end
        end
        for (int j = 0; j < IO_PER_BLK; j++) begin
            unique case (cpl_oe_t'(mcfg_r[2*j][MC_OE_LSB +: 2])) // [RULE_15]
                OE_OFF: oe_o[j] = 1'b0;
                OE_ON: oe_o[j] = 1'b1;
                OE_PT0: oe_o[j] = pt[PT_OE0];
                OE_PT1: oe_o[j] = pt[PT_OE1];
            endcase
        end
    end

    always_comb begin
        cfg_dat_o = '0;
        if (cfg_idx_i < TERM_END) begin
            cfg_dat_o[BLK_IN-1:0] = cfg_idx_i[0] ? cmask_r[cfg_idx_i[7:1]] : tmask_r[cfg_idx_i[7:1]];
        end else if (cfg_idx_i[9:4] == MC_BASE[9:4]) begin
            cfg_dat_o[MC_CFG_W-1:0] = mcfg_r[cfg_idx_i[3:0]];
        end else if (cfg_idx_i[9:4] == CLU_BASE[9:4]) begin
            cfg_dat_o[CLU_CFG_W-1:0] = clu_r[cfg_idx_i[3:0]];
        end else if (cfg_idx_i == STAT_OFF) begin
            cfg_dat_o[NUM_MC-1:0] = mc_o;
        end
    end

    arst_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) arst |=> st_r == '0) // [RULE_05]
        else $error("Reset term did not clear all storage");
    apre_set_a: assert property ( // [RULE_05]
        @(posedge clk_i) disable iff (rst_i) (!arst && apre) |=> st_r == {NUM_MC{1'b1}})
        else $error("Preset term did not set all storage");

    for (genvar k = 0; k < NUM_MC; k++) begin : g_chk
        dff_capture_a: assert property ( // [RULE_12]
            @(posedge clk_i) disable iff (rst_i)
            (mode_of(mcfg_r[k], k) == MD_REG && !mcfg_r[k][MC_TFF] && ck_rise_i[mcfg_r[k][MC_CKS]]
             && !arst && !apre) |=> st_r[k] == $past(fn[k]))
            else $error("D register did not capture on edge");
        tff_toggle_a: assert property ( // [RULE_17]
            @(posedge clk_i) disable iff (rst_i)
            (mode_of(mcfg_r[k], k) == MD_REG && mcfg_r[k][MC_TFF] && ck_rise_i[mcfg_r[k][MC_CKS]]
             && !arst && !apre) |=> st_r[k] == ($past(st_r[k]) ^ $past(fn[k])))
            else $error("T register toggled wrongly");
        reg_hold_a: assert property ( // [RULE_11]
            @(posedge clk_i) disable iff (rst_i)
            (mode_of(mcfg_r[k], k) == MD_REG && !ck_rise_i[mcfg_r[k][MC_CKS]] && !arst && !apre)
            |=> $stable(st_r[k]))
            else $error("Register changed without its clock edge");
        latch_hold_a: assert property ( // [RULE_13]
            @(posedge clk_i) disable iff (rst_i)
            (mode_of(mcfg_r[k], k) == MD_LATCH && ck_lvl_i[mcfg_r[k][MC_CKS]] && !arst && !apre)
            |=> $stable(st_r[k]))
            else $error("Latch changed while gate high");
    end
endmodule

// file: verification/tb_cpl_top.sv
// Self-checking bench of the logic fabric top; configures block 0 over Wishbone.
// Assumes a pin change reaches io_o within six clock edges; each check waits eight.
`timescale 1ns/1ps
module tb_cpl_top;
    import cpl_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [NUM_IO-1:0] pin_ext = 32'h0;
    logic [NUM_IO-1:0] io_i;
    logic [NUM_IO-1:0] io_o;
    logic [NUM_IO-1:0] io_oe_o;
    logic [NUM_DIN-1:0] din_i = 4'h0;
    logic [NUM_CKP-1:0] ckp_i = 2'h0;
    logic [31:0] rd;
    int bad_count = 0;
    int checks = 0;

    always #5 clk_i = ~clk_i;
    // Wire level: the fabric wins where it drives
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & pin_ext);

    cpl_top u_cpl_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
        .din_i(din_i), .ckp_i(ckp_i));

    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Block 0 word access; called just after a rising edge
    task wb(input logic we, input logic [3:0] sel, input logic [9:0] idx, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= {4'h0, idx, 2'h0};
        wb_dat_i <= d;
        @(posedge clk_i);
        // A missing answer is left to the watchdog
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task wr(input logic [9:0] idx, input logic [31:0] d);
        wb(1'b1, 4'hF, idx, d);
    endtask

    task settle;
        repeat (8) @(posedge clk_i);
    endtask

    task pulse(input int p);
        ckp_i[p] <= 1'b1;
        settle;
        ckp_i[p] <= 1'b0;
        settle;
    endtask

    task out0(input logic exp, input string what);
        settle;
        chk(32'(io_o[0]), 32'(exp), what);
    endtask

    task t_reset;
        wb(1'b0, 4'hF, MC_BASE, 32'h0);
        chk(rd, 32'(MC_CFG_RST), "cell cfg reset");
        wb(1'b0, 4'hF, ROUTE_BASE, 32'h0);
        chk(rd, 32'(ROUTE_RST), "route reset");
        wb(1'b0, 4'hF, 10'h001, 32'h0);
        chk(rd, 32'(PT_MASK_RST), "term mask reset");
        wb(1'b0, 4'hF, 10'h3F0, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        wb(1'b1, 4'h3, MC_BASE, 32'h7F);
        wb(1'b0, 4'hF, MC_BASE, 32'h0);
        chk(rd, 32'h0, "partial write");
        $display("test reset done");
    endtask

    // Term 0 = routed input 0, cluster 0 steered to cell 0
    task t_comb;
        wr(ROUTE_BASE, 32'h01);
        wr(10'h000, 32'h1);
        wr(10'h001, 32'h0);
        wr(CLU_BASE, 32'h5);
        wr(MC_BASE, 32'h20);
        pin_ext[1] <= 1'b1;
        out0(1'b1, "comb high");
        chk(32'(io_oe_o[0]), 32'h1, "oe on");
        pin_ext[1] <= 1'b0;
        out0(1'b0, "comb low");
        wr(MC_BASE, 32'h24);
        out0(1'b1, "inverted");
        wr(MC_BASE, 32'h00);
        settle;
        chk(32'(io_oe_o[0]), 32'h0, "oe off");
        wr(10'h080, 32'h1);
        wr(10'h081, 32'h0);
        wr(MC_BASE, 32'h40);
        pin_ext[1] <= 1'b1;
        settle;
        chk(32'(io_oe_o[0]), 32'h1, "oe term 0 true");
        wr(MC_BASE, 32'h60);
        settle;
        chk(32'(io_oe_o[0]), 32'h0, "oe term 1 erased");
        pin_ext[1] <= 1'b0;
        $display("test comb done");
    endtask

    task t_reg;
        wr(ROUTE_BASE, 32'h20);
        wr(ROUTE_BASE + 10'h001, 32'h21);
        wr(MC_BASE, 32'h21);
        din_i[0] <= 1'b1;
        out0(1'b0, "no edge yet");
        pulse(0);
        chk(32'(io_o[0]), 32'h1, "load on rise");
        // Data settles before the edge: it takes one stage more than the clock event
        din_i[0] <= 1'b0;
        settle;
        ckp_i[0] <= 1'b1;
        out0(1'b0, "second rise");
        ckp_i[0] <= 1'b0;
        din_i[0] <= 1'b1;
        out0(1'b0, "fall ignored");
        wr(MC_BASE, 32'h31);
        pulse(0);
        chk(32'(io_o[0]), 32'h0, "other pin ignored");
        pulse(1);
        chk(32'(io_o[0]), 32'h1, "pin 1 clock");
        wr(MC_BASE, 32'h29);
        pulse(0);
        chk(32'(io_o[0]), 32'h0, "toggle");
        pulse(0);
        chk(32'(io_o[0]), 32'h1, "toggle back");
        din_i[0] <= 1'b0;
        settle;
        pulse(0);
        chk(32'(io_o[0]), 32'h1, "toggle hold");
        wr(10'h084, 32'h2);
        wr(10'h085, 32'h0);
        wr(10'h086, 32'h2);
        wr(10'h087, 32'h0);
        din_i[1] <= 1'b1;
        out0(1'b0, "reset wins");
        wr(10'h085, 32'h2);
        out0(1'b1, "preset");
        din_i[1] <= 1'b0;
        $display("test register done");
    endtask

    task t_latch;
        wr(MC_BASE, 32'h22);
        din_i[0] <= 1'b1;
        out0(1'b1, "transparent high");
        din_i[0] <= 1'b0;
        out0(1'b0, "transparent low");
        ckp_i[0] <= 1'b1;
        settle;
        din_i[0] <= 1'b1;
        out0(1'b0, "gate high holds");
        ckp_i[0] <= 1'b0;
        out0(1'b1, "gate low again");
        $display("test latch done");
    endtask

    task t_alloc;
        wr(MC_BASE, 32'h20);
        for (int off = 0; off < 4; off++) begin
            wr(CLU_BASE, 32'(1 + 2 * off));
            settle;
            wb(1'b0, 4'hF, STAT_OFF, 32'h0);
            chk(rd, (off < 2) ? 32'h0 : 32'h1 << (off - 2), "cluster steering");
        end
        chk(32'(io_o[0]), 32'h0, "buried not on pin");
        wr(CLU_BASE, 32'h5);
        wr(ROUTE_BASE, 32'h24);
        ckp_i[0] <= 1'b1;
        out0(1'b1, "clock pin as data");
        wr(ROUTE_BASE + 10'h001, 32'h24);
        wr(ROUTE_BASE, 32'h26);
        ckp_i[0] <= 1'b0;
        out0(1'b1, "feedback holds");
        $display("test allocator done");
    endtask

    // Buried cell 1 samples pin 0 of the block; preset term erased first
    task t_input;
        wr(10'h087, 32'h2);
        wr(MC_BASE, 32'h00);
        wr(MC_BASE + 10'h001, 32'h03);
        pulse(0);
        pin_ext[0] <= 1'b1;
        settle;
        wb(1'b0, 4'hF, STAT_OFF, 32'h0);
        chk(32'(rd[1]), 32'h0, "input reg holds");
        pulse(0);
        wb(1'b0, 4'hF, STAT_OFF, 32'h0);
        chk(32'(rd[1]), 32'h1, "input reg loads");
        wr(MC_BASE + 10'h001, 32'h0B);
        ckp_i[0] <= 1'b1;
        settle;
        pin_ext[0] <= 1'b0;
        settle;
        wb(1'b0, 4'hF, STAT_OFF, 32'h0);
        chk(32'(rd[1]), 32'h1, "input latch holds");
        ckp_i[0] <= 1'b0;
        settle;
        wb(1'b0, 4'hF, STAT_OFF, 32'h0);
        chk(32'(rd[1]), 32'h0, "input latch open");
        $display("test input cell done");
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_of_test;
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_comb;
        t_reg;
        t_latch;
        t_alloc;
        t_input;
        end_of_test;
    end
endmodule
